// ---- flash_pd_params.svh ----
// constants for the power-down and status-lock command block
`ifndef FLASH_PD_PARAMS_SVH
`define FLASH_PD_PARAMS_SVH

`define OP_LOCK_CODE    8'h6f
`define LOCK_VER1_CODE  8'h4d
`define LOCK_VER2_CODE  8'h67
`define OP_DEEP_CODE    8'hb9
`define OP_ULTRA_CODE   8'h79
`define OP_RESUME_CODE  8'hab

`define BYTE_LAST_BIT   3'h7
`define ID_START_BYTES  3'h4

`define CLK_MHZ         40
`define T_EDPD_NS       3000
`define T_EUDPD_NS      3000
`define T_RDPD_NS       8000
`define T_RUDPD_NS      20000
`define T_EDPD_CYC      ((`T_EDPD_NS * `CLK_MHZ) / 1000)
`define T_EUDPD_CYC     ((`T_EUDPD_NS * `CLK_MHZ) / 1000)
`define T_RDPD_CYC      ((`T_RDPD_NS * `CLK_MHZ) / 1000)
`define T_RUDPD_CYC     ((`T_RUDPD_NS * `CLK_MHZ) / 1000)
`define TIMER_W         12
`define FRAME_SYNC_CYC  4

`endif

// ---- flash_pd_pkg.sv ----
// types shared by the power-down and status-lock command block
package flash_pd_pkg;

  typedef enum logic [4:0] {
    OP_NONE   = 5'b00001,
    OP_LOCK   = 5'b00010,
    OP_DEEP   = 5'b00100,
    OP_ULTRA  = 5'b01000,
    OP_RESUME = 5'b10000
  } op_kind_e;

  typedef enum logic [6:0] {
    ST_STANDBY     = 7'b0000001,
    ST_ENTER_DEEP  = 7'b0000010,
    ST_DEEP        = 7'b0000100,
    ST_ENTER_ULTRA = 7'b0001000,
    ST_ULTRA       = 7'b0010000,
    ST_WAKE_DEEP   = 7'b0100000,
    ST_WAKE_ULTRA  = 7'b1000000
  } pd_state_e;

endpackage

// ---- flash_pd_link.sv ----
// serial-clock side: bit framing, opcode decode and identifier output
`timescale 1ns/10ps
`include "flash_pd_params.svh"

module flash_pd_link
  import flash_pd_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
) (
  input  wire logic     rst_i,
  input  wire logic     sclk_i,
  input  wire logic     cs_n_i,
  input  wire logic     si_i,
  input  wire logic     ultra_state_i,
  output op_kind_e      op_kind_o,
  output logic          lock_ok_o,
  output logic          aligned_o,
  output logic          so_o,
  output logic          so_oe_o
);

  function automatic op_kind_e decode_op(input logic [7:0] code);
    case (code)
      `OP_LOCK_CODE:   decode_op = OP_LOCK;
      `OP_DEEP_CODE:   decode_op = OP_DEEP;
      `OP_ULTRA_CODE:  decode_op = OP_ULTRA;
      `OP_RESUME_CODE: decode_op = OP_RESUME;
      default:         decode_op = OP_NONE;
    endcase
  endfunction

  logic       link_rst;
  logic [2:0] bit_idx_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_next;
  logic       ver1_ok_reg;
  logic       ultra_meta_reg;
  logic       ultra_sync_reg;

  // counters restart whenever chip select is high
  assign link_rst  = rst_i | cs_n_i;
  assign byte_next = {shift_reg[6:0], si_i};

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_idx_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg    <= 8'h00;
    end else begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      shift_reg   <= byte_next;
      if (bit_idx_reg == `BYTE_LAST_BIT && byte_cnt_reg != `ID_START_BYTES) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // decode results survive chip select so the core can act on them
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      op_kind_o   <= OP_NONE;
      lock_ok_o   <= 1'b0;
      ver1_ok_reg <= 1'b0;
      aligned_o   <= 1'b1;
    end else begin
      aligned_o <= (bit_idx_reg == `BYTE_LAST_BIT);
      if (bit_idx_reg == `BYTE_LAST_BIT) begin
        case (byte_cnt_reg)
          3'h0: begin
            op_kind_o   <= decode_op(byte_next);
            ver1_ok_reg <= 1'b0;
            lock_ok_o   <= 1'b0;
          end
          3'h1: ver1_ok_reg <= (byte_next == `LOCK_VER1_CODE);
          3'h2: lock_ok_o <= ver1_ok_reg && (byte_next == `LOCK_VER2_CODE);
          default: ;
        endcase
      end else if (bit_idx_reg == 3'h0 && byte_cnt_reg == 3'h0) begin
        op_kind_o <= OP_NONE;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ultra_meta_reg <= 1'b0;
      ultra_sync_reg <= 1'b0;
    end else begin
      ultra_meta_reg <= ultra_state_i;
      ultra_sync_reg <= ultra_meta_reg;
    end
  end

  // identifier after three dummy bytes, repeated until chip select rises
  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (op_kind_o == OP_RESUME && !ultra_sync_reg &&
                 byte_cnt_reg == `ID_START_BYTES) begin
      so_o    <= DEVICE_ID[3'h7 - bit_idx_reg];
      so_oe_o <= 1'b1;
    end
  end

endmodule

// ---- flash_powerdown_lock_cmds.sv ----
// power-down, resume and status-lock command handling of the serial flash
`timescale 1ns/10ps
`include "flash_pd_params.svh"

module flash_powerdown_lock_cmds
  import flash_pd_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic write_enable_latch_i,
  input  wire logic status_protect_hi_i,
  input  wire logic status_protect_lo_i,
  input  wire logic power_down_mode_select_i,
  input  wire logic busy_flag_i,
  input  wire logic sr_write_req_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      wel_clear_o,
  output logic      status_locked_o,
  output logic      sr_write_grant_o,
  output logic      deep_sleep_state_o,
  output logic      ultra_sleep_state_o,
  output logic      standby_o,
  output logic      cmd_accept_o,
  output logic      reset_cmd_accept_o,
  output logic      device_reset_o
);

  localparam int EDPD_LIM  = `T_EDPD_CYC;
  localparam int EUDPD_LIM = `T_EUDPD_CYC;
  localparam int RDPD_LIM  = `T_RDPD_CYC;
  localparam int RUDPD_LIM = `T_RUDPD_CYC;

  // frame end is seen a few clocks after chip select rises; the timers give
  // that time back so each limit still holds when measured from the pin
  localparam logic [`TIMER_W-1:0] EDPD_CYC  = `TIMER_W'(EDPD_LIM - `FRAME_SYNC_CYC);
  localparam logic [`TIMER_W-1:0] EUDPD_CYC = `TIMER_W'(EUDPD_LIM - `FRAME_SYNC_CYC);
  localparam logic [`TIMER_W-1:0] RDPD_CYC  = `TIMER_W'(RDPD_LIM - `FRAME_SYNC_CYC);
  localparam logic [`TIMER_W-1:0] RUDPD_CYC = `TIMER_W'(RUDPD_LIM - `FRAME_SYNC_CYC);
  localparam logic [`TIMER_W-1:0] TIMER_ONE = `TIMER_W'(1);

  op_kind_e               op_kind;
  logic                   lock_ok;
  logic                   aligned;
  logic                   cs_meta_reg;
  logic                   cs_sync_reg;
  logic                   cs_prev_reg;
  logic                   frame_end;
  logic                   frame_ok;
  logic                   timer_done;
  logic                   in_standby;
  pd_state_e              state_reg;
  logic [`TIMER_W-1:0]    timer_reg;

  ////////////////////////////////////////////////////////////////////////////
  // serial-clock side

  flash_pd_link #(
    .DEVICE_ID (DEVICE_ID)
  ) u_link (
    .rst_i         (rst_i),
    .sclk_i        (sclk_i),
    .cs_n_i        (cs_n_i),
    .si_i          (si_i),
    .ultra_state_i (ultra_sleep_state_o),
    .op_kind_o     (op_kind),
    .lock_ok_o     (lock_ok),
    .aligned_o     (aligned),
    .so_o          (so_o),
    .so_oe_o       (so_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame end detection

  // decode results stop changing with the last serial edge; they are read
  // only once the synchronised chip select has risen, so they are settled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  assign frame_end  = cs_sync_reg && !cs_prev_reg;
  assign frame_ok   = frame_end && aligned && (op_kind != OP_NONE);
  assign timer_done = (timer_reg <= TIMER_ONE);
  assign in_standby = (state_reg == ST_STANDBY);

  ////////////////////////////////////////////////////////////////////////////
  // power state machine

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_STANDBY;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        ST_STANDBY: begin
          if (frame_ok && !busy_flag_i) begin
            if (op_kind == OP_DEEP && power_down_mode_select_i) begin
              state_reg <= ST_ENTER_DEEP;
              timer_reg <= EDPD_CYC;
            end else if (op_kind == OP_DEEP || op_kind == OP_ULTRA) begin
              state_reg <= ST_ENTER_ULTRA;
              timer_reg <= EUDPD_CYC;
            end
          end
        end
        ST_ENTER_DEEP: begin
          timer_reg <= timer_reg - TIMER_ONE;
          if (timer_done) begin
            state_reg <= ST_DEEP;
          end
        end
        ST_DEEP: begin
          if (frame_ok && op_kind == OP_RESUME) begin
            state_reg <= ST_WAKE_DEEP;
            timer_reg <= RDPD_CYC;
          end
        end
        ST_ENTER_ULTRA: begin
          timer_reg <= timer_reg - TIMER_ONE;
          if (timer_done) begin
            state_reg <= ST_ULTRA;
          end
        end
        ST_ULTRA: begin
          if (frame_ok && op_kind == OP_RESUME) begin
            state_reg <= ST_WAKE_ULTRA;
            timer_reg <= RUDPD_CYC;
          end
        end
        ST_WAKE_DEEP, ST_WAKE_ULTRA: begin
          timer_reg <= timer_reg - TIMER_ONE;
          if (timer_done) begin
            state_reg <= ST_STANDBY;
          end
        end
        default: begin
          state_reg <= ST_STANDBY;
          timer_reg <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state outputs

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      deep_sleep_state_o  <= 1'b0;
      ultra_sleep_state_o <= 1'b0;
      standby_o           <= 1'b1;
      cmd_accept_o        <= 1'b1;
      reset_cmd_accept_o  <= 1'b1;
    end else begin
      deep_sleep_state_o  <= (state_reg == ST_DEEP);
      ultra_sleep_state_o <= (state_reg == ST_ULTRA);
      standby_o           <= in_standby;
      cmd_accept_o        <= in_standby;
      reset_cmd_accept_o  <= in_standby || (state_reg == ST_DEEP);
    end
  end

  // internal reset pulse when ultra sleep is left by a resume
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      device_reset_o <= 1'b0;
    end else begin
      device_reset_o <= (state_reg == ST_ULTRA) && frame_ok &&
                        (op_kind == OP_RESUME);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status lock

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_locked_o <= 1'b0;
    end else if (frame_ok && in_standby && op_kind == OP_LOCK && lock_ok &&
                 write_enable_latch_i &&
                 status_protect_hi_i && status_protect_lo_i) begin
      status_locked_o <= 1'b1;
    end
  end

  // a lock frame taken in standby, whole or broken, always uses up the write enable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_clear_o <= 1'b0;
    end else begin
      wel_clear_o <= frame_end && in_standby && (op_kind == OP_LOCK);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_write_grant_o <= 1'b0;
    end else begin
      sr_write_grant_o <= sr_write_req_i && !status_locked_o && in_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence deep_req_s;
    frame_ok && in_standby && !busy_flag_i && op_kind == OP_DEEP &&
      power_down_mode_select_i;
  endsequence

  sequence ultra_req_s;
    frame_ok && in_standby && !busy_flag_i &&
      (op_kind == OP_ULTRA || (op_kind == OP_DEEP && !power_down_mode_select_i));
  endsequence

  sequence ultra_resume_s;
    frame_ok && state_reg == ST_ULTRA && op_kind == OP_RESUME;
  endsequence

  lock_needs_wel_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(status_locked_o) |-> $past(write_enable_latch_i) && $past(lock_ok))
    else $error("lock taken without write enable or verification bytes");

  lock_needs_prot_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(status_locked_o) |-> $past(status_protect_hi_i && status_protect_lo_i))
    else $error("lock taken without both protect bits");

  locked_no_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    status_locked_o |=> !sr_write_grant_o && status_locked_o)
    else $error("status write granted while locked");

  lock_wel_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    frame_end && in_standby && op_kind == OP_LOCK |=> wel_clear_o ##1 !wel_clear_o)
    else $error("lock frame did not clear write enable once");

  bad_frame_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    frame_end && !aligned && in_standby |=> in_standby && $stable(status_locked_o))
    else $error("misaligned frame changed the power state");

  busy_ignore_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    frame_end && in_standby && busy_flag_i |=> state_reg == ST_STANDBY)
    else $error("power-down taken while busy");

  deep_entry_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    deep_req_s |-> ##[1:EDPD_LIM] state_reg == ST_DEEP ##1 deep_sleep_state_o)
    else $error("deep sleep not reached in time");

  ultra_entry_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ultra_req_s |-> ##[1:EUDPD_LIM] state_reg == ST_ULTRA)
    else $error("ultra sleep not reached in time");

  deep_filter_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_reg == ST_DEEP && frame_end && op_kind != OP_RESUME |=> state_reg == ST_DEEP)
    else $error("deep sleep left by a command other than resume");

  ultra_filter_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state_reg == ST_ULTRA && frame_end && op_kind != OP_RESUME |=>
      state_reg == ST_ULTRA && !device_reset_o)
    else $error("ultra sleep left by a command other than resume");

  deep_resume_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    frame_ok && state_reg == ST_DEEP && op_kind == OP_RESUME |->
      ##[1:RDPD_LIM] in_standby)
    else $error("deep sleep resume too slow");

  ultra_resume_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ultra_resume_s |=> device_reset_o ##[1:RUDPD_LIM] in_standby)
    else $error("ultra sleep resume missed reset or standby time");

endmodule

// ---- spi_host_model.sv ----
// serial host model: frames commands on chip select, clock and serial input
`timescale 1ns/10ps
module spi_host_model (
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end

  // sends nbits from the top of bits_v; keeps the last 16 bits seen on the output
  task automatic xfer(input logic [47:0] bits_v, input int nbits, output logic [15:0] rx_v);
    rx_v = 16'h0;
    // two idle clocks with chip select high let the link side catch up on state
    repeat (2) begin
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #6 cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si_o = bits_v[47-i];
      #6;
      // a released output shows the inverse, so an undriven bit cannot pass
      rx_v = {rx_v[14:0], so_oe_i ? so_i : ~so_i};
      sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    // chip select rises after the last clock, byte-aligned or not as asked
    #6 cs_n_o = 1'b1;
    si_o = ~si_o;
    #150;
  endtask
endmodule

// ---- tb_flash_powerdown_lock_cmds.sv ----
// self-checking bench for the power-down, resume and status-lock block
`timescale 1ns/10ps
module tb_flash_powerdown_lock_cmds;
  localparam logic [7:0] ID = 8'hc3;  // arbitrary value
  typedef struct {
    logic [47:0] bits;
    int          nb;
    logic [3:0]  cfg;
    logic [3:0]  exp;
    logic [15:0] rx;
  } row_s;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        write_enable_latch = 1'b0, sp_hi = 1'b0, sp_lo = 1'b0, power_down_mode_select = 1'b0, busy = 1'b0, req = 1'b0;
  logic        cs_n, sclk, si, so, so_oe;
  logic        wclr_o, locked, grant, deep, ultra, stby, acc, racc, dres;
  logic        wclr_seen, dres_seen, oe_seen;
  logic [15:0] rx;
  int          error_cnt = 0;
  int          check_count = 0;
  int          t;
  row_s        rows[12];

  always #12.5 clk_i = ~clk_i;

  flash_powerdown_lock_cmds #(.DEVICE_ID(ID)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .write_enable_latch_i(write_enable_latch),
    .status_protect_hi_i(sp_hi), .status_protect_lo_i(sp_lo),
    .power_down_mode_select_i(power_down_mode_select), .busy_flag_i(busy), .sr_write_req_i(req),
    .so_o(so), .so_oe_o(so_oe), .wel_clear_o(wclr_o), .status_locked_o(locked),
    .sr_write_grant_o(grant), .deep_sleep_state_o(deep), .ultra_sleep_state_o(ultra),
    .standby_o(stby), .cmd_accept_o(acc), .reset_cmd_accept_o(racc),
    .device_reset_o(dres));

  spi_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so), .so_oe_i(so_oe));

  // sticky records of one-cycle pulses and of the output driver turning on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wclr_seen <= 1'b0;
      dres_seen <= 1'b0;
      oe_seen   <= 1'b0;
    end else begin
      wclr_seen <= wclr_seen | wclr_o;
      dres_seen <= dres_seen | dres;
      oe_seen   <= oe_seen | so_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic set_in(input logic [3:0] c, input logic b);
    @(negedge clk_i);
    {write_enable_latch, sp_hi, sp_lo, power_down_mode_select} = c;
    busy = b;
  endtask

  task automatic send(input logic [47:0] b, input int n);
    host_u.xfer(b, n, rx);
    repeat (140) @(negedge clk_i);
  endtask

  task automatic wait_stby(input int lim);
    for (t = 0; t < lim && stby !== 1'b1; t++) @(negedge clk_i);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    error_cnt++;
    results();
  end

  initial begin
    // cfg is {wel, protect hi, protect lo, mode select}, exp is {locked, deep, ultra, wel clear}
    rows[0]  = '{{8'h6f, 8'h4d, 8'h67, 24'h0}, 24, 4'b1110, 4'b1001, 16'h0};
    rows[1]  = '{{8'h6f, 8'h4d, 8'h67, 24'h0}, 24, 4'b0110, 4'b0001, 16'h0};
    rows[2]  = '{{8'h6f, 8'h4d, 8'h67, 24'h0}, 24, 4'b1100, 4'b0001, 16'h0};
    rows[3]  = '{{8'h6f, 8'h67, 8'h4d, 24'h0}, 24, 4'b1110, 4'b0001, 16'h0};
    rows[4]  = '{{8'h6f, 8'h4d, 8'h66, 24'h0}, 24, 4'b1110, 4'b0001, 16'h0};
    rows[5]  = '{{8'h6f, 8'h4d, 8'h67, 24'h0}, 27, 4'b1110, 4'b0001, 16'h0};
    rows[6]  = '{{8'h6f, 8'h4d, 32'h0}, 16, 4'b1110, 4'b0001, 16'h0};
    rows[7]  = '{{8'hb9, 40'h0}, 8, 4'b0001, 4'b0100, 16'h0};
    rows[8]  = '{{8'hb9, 40'h0}, 8, 4'b0000, 4'b0010, 16'h0};
    rows[9]  = '{{8'h79, 40'h0}, 8, 4'b0001, 4'b0010, 16'h0};
    rows[10] = '{{8'hb9, 40'h0}, 11, 4'b0001, 4'b0000, 16'h0};
    rows[11] = '{{8'hab, 40'h0}, 48, 4'b0000, 4'b0000, {ID, ID}};
    do_reset();
    chk("reset_outs", 10'b0000001110, {so_oe, wclr_o, locked, grant, deep, ultra, stby, acc,
        racc, dres});
    for (int i = 0; i < 12; i++) begin
      do_reset();
      set_in(rows[i].cfg, 1'b0);
      send(rows[i].bits, rows[i].nb);
      chk("locked", rows[i].exp[3], locked);
      chk("deep_ultra", rows[i].exp[2:1], {deep, ultra});
      chk("standby", !(rows[i].exp[2] | rows[i].exp[1]), stby);
      chk("wel_clear", rows[i].exp[0], wclr_seen);
      if (rows[i].nb == 48) chk("id_out", rows[i].rx, rx);
      if (rows[i].nb == 48) chk("id_oe", 1, oe_seen);
      $display("row %0d done", i);
    end

    do_reset();
    set_in(4'b1110, 1'b0);
    req = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("grant_open", 1, grant);
    send({8'h6f, 8'h4d, 8'h67, 24'h0}, 24);
    chk("grant_locked", 0, grant);
    req = 1'b0;
    $display("lock refusal test done");

    do_reset();
    set_in(4'b1111, 1'b1);
    send({8'hb9, 40'h0}, 8);
    chk("busy_ignored", 2'b01, {deep, stby});
    set_in(4'b1111, 1'b0);
    send({8'hb9, 40'h0}, 8);
    chk("deep_accept", 3'b101, {deep, acc, racc});
    send({8'h6f, 8'h4d, 8'h67, 24'h0}, 24);
    chk("lock_in_deep", 0, locked);
    send({8'hab, 40'h0}, 8);
    wait_stby(400);
    chk("deep_exit", 2'b01, {deep, stby});
    send({8'hb9, 40'h0}, 8);
    send({8'hab, 40'h0}, 48);
    chk("id_deep", {ID, ID}, rx);
    wait_stby(400);
    chk("id_exit", 2'b01, {deep, stby});
    $display("deep sleep test done");

    do_reset();
    set_in(4'b1110, 1'b0);
    send({8'h79, 40'h0}, 8);
    chk("racc_ultra", 2'b10, {ultra, racc});
    send({8'h6f, 8'h4d, 8'h67, 24'h0}, 24);
    chk("lock_in_ultra", 0, locked);
    send({8'hab, 40'h0}, 48);
    chk("no_id_ultra", 0, oe_seen);
    wait_stby(900);
    chk("ultra_exit", 3'b110, {dres_seen, stby, ultra});
    $display("ultra sleep test done");
    results();
  end
endmodule
